// File: src/lcs_params.svh
// Offsets, field positions and reset values of the command/status unit
// Operation
// - Command-unit command codes decode to eight actions
// - Receive-unit command codes decode to eight actions
// - Software interrupt request and interrupt mask bits
// - Command-done event, or transmit-failed by option
// - Frame-received event on whole frame or header
// - Command-inactive event on leaving active, optionally idle
// - Receive-not-ready event whenever ready is left
// - Management event when enabled; software event on request
// - Report command-unit and receive-unit states
// - Host writes command word; device updates status word
// - Selective reset idles both units, keeps configuration
// - No full reset in command word; port register
// - Sixteen statistics counters update automatically
// - Transmit complete once frame copied from memory
// - Transmit starts when FIFO reaches threshold
// - Separate transmit and receive DMA preempt counts
// - Independent 3 Kbyte transmit and receive FIFOs
// - Fixed 64 byte minimum frame length
// - Little-endian only, single linear addressing mode
// - Bus bursts up to 256 doublewords
// - Three receive descriptor formats supported
// - Adaptive interframe spacing instead of manual tuning
`ifndef LCS_PARAMS_SVH
`define LCS_PARAMS_SVH
// Register byte offsets
`define LCS_OFF_STATUS    8'h00
`define LCS_OFF_CMD       8'h04
`define LCS_OFF_PORT      8'h08
`define LCS_OFF_GPTR      8'h0c
`define LCS_OFF_CFG       8'h10
`define LCS_OFF_STAT_SEL  8'h14
`define LCS_OFF_STAT_DATA 8'h18
// Command word fields
`define LCS_CMD_CU_LSB    0
`define LCS_CMD_RU_LSB    4
`define LCS_CMD_MASK_BIT  8
`define LCS_CMD_SWI_BIT   9
// Status word fields
`define LCS_ST_CU_LSB     0
`define LCS_ST_RU_LSB     2
`define LCS_ST_EV_LSB     8
// Event bit positions
`define LCS_EV_CX   0
`define LCS_EV_FR   1
`define LCS_EV_CNA  2
`define LCS_EV_RNR  3
`define LCS_EV_MGMT 4
`define LCS_EV_SWI  5
`define LCS_EV_NUM  6
// Configuration fields
`define LCS_CFG_TNO_BIT    0
`define LCS_CFG_CNAIDLE_BIT 1
`define LCS_CFG_MGMT_BIT   2
`define LCS_CFG_AIFS_BIT   3
`define LCS_CFG_RFD_LSB    4
`define LCS_CFG_THR_LSB    8
`define LCS_CFG_TXPRE_LSB  16
`define LCS_CFG_RXPRE_LSB  24
`define LCS_CFG_RST        32'h0808_1008
// Port functions
`define LCS_PORT_SOFT_RST  4'h0
`define LCS_PORT_SELFTEST  4'h1
`define LCS_PORT_SEL_RST   4'h2
`define LCS_PORT_DUMP      4'h3
// Fixed device figures
`define LCS_MIN_FRAME      12'h040
`define LCS_FIFO_BYTES     12'hc00
`define LCS_BURST_DW       9'h100
`define LCS_NUM_STATS      16
`endif

// File: src/lcs_pkg.sv
// Types shared by the command/status unit
package lcs_pkg;
  typedef enum logic [1:0] {
    LCS_CU_IDLE, LCS_CU_SUSP, LCS_CU_ACTIVE
  } lcs_cu_state_e;
  typedef enum logic [2:0] {
    LCS_RU_IDLE, LCS_RU_SUSP, LCS_RU_SUSP_NORBD, LCS_RU_NORES,
    LCS_RU_NORES_NORBD, LCS_RU_READY, LCS_RU_READY_NORBD
  } lcs_ru_state_e;
  typedef enum logic [2:0] {
    LCS_CU_NOP = 3'h0, LCS_CU_START = 3'h1, LCS_CU_RESUME = 3'h2,
    LCS_CU_RSVD = 3'h3, LCS_CU_LD_DUMP = 3'h4, LCS_CU_DUMP = 3'h5,
    LCS_CU_LD_BASE = 3'h6, LCS_CU_DUMP_CLR = 3'h7
  } lcs_cu_cmd_e;
  typedef enum logic [2:0] {
    LCS_RU_NOP = 3'h0, LCS_RU_START = 3'h1, LCS_RU_RESUME = 3'h2,
    LCS_RU_RSVD = 3'h3, LCS_RU_ABORT = 3'h4, LCS_RU_LD_HDR = 3'h5,
    LCS_RU_LD_BASE = 3'h6, LCS_RU_RBD_RESUME = 3'h7
  } lcs_ru_cmd_e;
  typedef enum logic [1:0] {
    LCS_RFD_SIMPLE = 2'h0, LCS_RFD_FLEX = 2'h1, LCS_RFD_HEADER = 2'h2
  } lcs_rfd_fmt_e;
  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    lcs_cu_state_e cu;
    lcs_ru_state_e ru;
    logic [31:0]   cfg;
    logic [31:0]   gptr;
    logic [31:0]   cu_base;
    logic [31:0]   ru_base;
    logic [31:0]   dump_addr;
    logic [31:0]   hdr_size;
    logic          irq_mask;
    logic [3:0]    stat_sel;
    logic          dump_req;
    logic          dump_clr;
    logic          selftest_req;
    logic          tx_start;
    logic          rx_discard;
    logic          irq;
  } lcs_top_s;
endpackage : lcs_pkg

// File: src/lcs_event_latch.sv
// Sticky event flags, set by hardware and cleared by write-one
module lcs_event_latch #(
  parameter int N = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] flags
);
  typedef struct packed {
    logic [N-1:0] flags;
  } lcs_latch_s;
  lcs_latch_s s;
  lcs_latch_s next_s;

  // Set beats a clear arriving in the same cycle
  always_comb begin
    next_s = s;
    for (int i = 0; i < N; i++) begin
      next_s.flags[i] = set[i] | (s.flags[i] & ~clr[i]);
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;
endmodule // lcs_event_latch

// File: src/lcs_stats.sv
// Bank of statistics counters with selectable readout
module lcs_stats #(
  parameter int N = 16,
  parameter int W = 32
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [N-1:0]         inc,
  input  wire logic                 clr,
  input  wire logic [$clog2(N)-1:0] sel,
  output logic      [W-1:0]         value
);
  typedef struct packed {
    logic [N-1:0][W-1:0] cnt;
    logic [W-1:0]        value;
  } lcs_stats_s;
  lcs_stats_s s;
  lcs_stats_s next_s;

  // Count each completion pulse; clear restarts from this cycle's pulse
  always_comb begin
    next_s = s;
    for (int i = 0; i < N; i++) begin
      if (clr) begin
        next_s.cnt[i] = {{(W-1){1'b0}}, inc[i]};
      end else begin
        next_s.cnt[i] = s.cnt[i] + {{(W-1){1'b0}}, inc[i]};
      end
    end
    next_s.value = s.cnt[sel];
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign value = s.value;
endmodule // lcs_stats

// File: src/lcs_ctrl.sv
// Command word, status word and unit state control behind AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "lcs_params.svh"
module lcs_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cmd_done,
  input  wire logic        cmd_ibit,
  input  wire logic        tx_copied,
  input  wire logic        tx_bad,
  input  wire logic        cu_list_end,
  input  wire logic        cu_suspend,
  input  wire logic        frame_done,
  input  wire logic [11:0] frame_len,
  input  wire logic        header_done,
  input  wire logic        ru_suspend,
  input  wire logic        ru_no_res,
  input  wire logic        ru_no_rbd,
  input  wire logic        ru_rbd_out,
  input  wire logic        mgmt_done,
  input  wire logic [15:0] stat_inc,
  input  wire logic [11:0] tx_level,
  output logic             irq,
  output logic [1:0]       cu_state,
  output logic [2:0]       ru_state,
  output logic [31:0]      cu_base,
  output logic [31:0]      ru_base,
  output logic [31:0]      dump_addr,
  output logic [31:0]      hdr_size,
  output logic             dump_req,
  output logic             dump_clr,
  output logic             selftest_req,
  output logic             tx_start,
  output logic             rx_discard,
  output logic [7:0]       tx_preempt,
  output logic [7:0]       rx_preempt,
  output logic [1:0]       rfd_format,
  output logic             adaptive_ifs
);
  lcs_pkg::lcs_top_s s;
  lcs_pkg::lcs_top_s next_s;
  logic [`LCS_EV_NUM-1:0] ev_set;
  logic [`LCS_EV_NUM-1:0] ev_clr;
  logic [`LCS_EV_NUM-1:0] ev_flags;
  logic [31:0]            stat_value;
  logic                   wr;
  logic                   rd;
  logic                   cmd_wr;
  logic                   port_wr;
  logic                   sel_rst;
  logic                   full_rst;
  logic                   ru_was_ready;
  logic                   ru_is_ready;
  logic [11:0]            thr_bytes;
  lcs_pkg::lcs_cu_cmd_e   cu_cmd;
  lcs_pkg::lcs_ru_cmd_e   ru_cmd;

  // Apply write strobes byte by byte
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Handshake decode and derived strobes
  assign wr       = s.awready && awvalid && wvalid;
  assign rd       = s.arready && arvalid;
  assign cmd_wr   = wr && (awaddr == `LCS_OFF_CMD);
  assign port_wr  = wr && (awaddr == `LCS_OFF_PORT) && wstrb[0];
  assign full_rst = port_wr && (wdata[3:0] == `LCS_PORT_SOFT_RST);
  assign sel_rst  = port_wr && (wdata[3:0] == `LCS_PORT_SEL_RST);
  assign cu_cmd   = lcs_pkg::lcs_cu_cmd_e'(wdata[`LCS_CMD_CU_LSB +: 3]);
  assign ru_cmd   = lcs_pkg::lcs_ru_cmd_e'(wdata[`LCS_CMD_RU_LSB +: 3]);
  assign thr_bytes = {1'b0, s.cfg[`LCS_CFG_THR_LSB +: 8], 3'h0};

  // Next-state logic: bus slave, unit state machines, event sources
  always_comb begin
    next_s = s;
    next_s.dump_req     = 1'b0;
    next_s.dump_clr     = 1'b0;
    next_s.selftest_req = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    // Write channel: take address and data together
    next_s.awready = awvalid && wvalid && !s.awready && !s.bvalid;
    next_s.wready  = awvalid && wvalid && !s.awready && !s.bvalid;
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // Read channel
    next_s.arready = arvalid && !s.arready && !s.rvalid;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    // Datapath reports move the units first
    if (cu_list_end) begin
      next_s.cu = lcs_pkg::LCS_CU_IDLE;
    end else if (cu_suspend) begin
      next_s.cu = lcs_pkg::LCS_CU_SUSP;
    end
    if (ru_rbd_out) begin
      next_s.ru = lcs_pkg::LCS_RU_NORES_NORBD;
    end else if (ru_no_res) begin
      next_s.ru = lcs_pkg::LCS_RU_NORES;
    end else if (ru_suspend) begin
      if (s.ru == lcs_pkg::LCS_RU_READY_NORBD) begin
        next_s.ru = lcs_pkg::LCS_RU_SUSP_NORBD;
      end else begin
        next_s.ru = lcs_pkg::LCS_RU_SUSP;
      end
    end else if (ru_no_rbd && s.ru == lcs_pkg::LCS_RU_READY) begin
      next_s.ru = lcs_pkg::LCS_RU_READY_NORBD;
    end
    // Register writes
    if (wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = 2'b00;
      if (awaddr == `LCS_OFF_STATUS) begin
        ev_clr = wdata[`LCS_ST_EV_LSB +: `LCS_EV_NUM] &
                 {`LCS_EV_NUM{wstrb[1]}};
      end else if (awaddr == `LCS_OFF_CMD) begin
        if (wstrb[1]) begin
          next_s.irq_mask = wdata[`LCS_CMD_MASK_BIT];
          ev_set[`LCS_EV_SWI] = wdata[`LCS_CMD_SWI_BIT];
        end
      end else if (awaddr == `LCS_OFF_PORT) begin
        if (wstrb[0] && wdata[3:0] == `LCS_PORT_SELFTEST) begin
          next_s.selftest_req = 1'b1;
        end
        if (wstrb[0] && wdata[3:0] == `LCS_PORT_DUMP) begin
          next_s.dump_req = 1'b1;
        end
      end else if (awaddr == `LCS_OFF_GPTR) begin
        next_s.gptr = merge(s.gptr, wdata, wstrb);
      end else if (awaddr == `LCS_OFF_CFG) begin
        next_s.cfg = merge(s.cfg, wdata, wstrb);
      end else if (awaddr == `LCS_OFF_STAT_SEL) begin
        if (wstrb[0]) begin
          next_s.stat_sel = wdata[3:0];
        end
      end else if (awaddr != `LCS_OFF_STAT_DATA) begin
        next_s.bresp = 2'b10;
      end
    end
    // Command-unit commands
    if (cmd_wr && wstrb[0]) begin
      case (cu_cmd)
        lcs_pkg::LCS_CU_START: next_s.cu = lcs_pkg::LCS_CU_ACTIVE;
        lcs_pkg::LCS_CU_RESUME: begin
          if (s.cu == lcs_pkg::LCS_CU_SUSP) begin
            next_s.cu = lcs_pkg::LCS_CU_ACTIVE;
          end
        end
        lcs_pkg::LCS_CU_LD_DUMP: next_s.dump_addr = s.gptr;
        lcs_pkg::LCS_CU_DUMP: next_s.dump_req = 1'b1;
        lcs_pkg::LCS_CU_LD_BASE: next_s.cu_base = s.gptr;
        lcs_pkg::LCS_CU_DUMP_CLR: begin
          next_s.dump_req = 1'b1;
          next_s.dump_clr = 1'b1;
        end
        default: ;
      endcase
      // Receive-unit commands
      case (ru_cmd)
        lcs_pkg::LCS_RU_START: next_s.ru = lcs_pkg::LCS_RU_READY;
        lcs_pkg::LCS_RU_RESUME: begin
          if (s.ru == lcs_pkg::LCS_RU_SUSP) begin
            next_s.ru = lcs_pkg::LCS_RU_READY;
          end else if (s.ru == lcs_pkg::LCS_RU_SUSP_NORBD) begin
            next_s.ru = lcs_pkg::LCS_RU_READY_NORBD;
          end
        end
        lcs_pkg::LCS_RU_ABORT: next_s.ru = lcs_pkg::LCS_RU_IDLE;
        lcs_pkg::LCS_RU_LD_HDR: next_s.hdr_size = s.gptr;
        lcs_pkg::LCS_RU_LD_BASE: next_s.ru_base = s.gptr;
        lcs_pkg::LCS_RU_RBD_RESUME: begin
          if (s.ru == lcs_pkg::LCS_RU_READY_NORBD ||
              s.ru == lcs_pkg::LCS_RU_NORES_NORBD) begin
            next_s.ru = lcs_pkg::LCS_RU_READY;
          end else if (s.ru == lcs_pkg::LCS_RU_SUSP_NORBD) begin
            next_s.ru = lcs_pkg::LCS_RU_SUSP;
          end
        end
        default: ;
      endcase
    end
    // Selective and software resets through the port register
    if (sel_rst || full_rst) begin
      next_s.cu = lcs_pkg::LCS_CU_IDLE;
      next_s.ru = lcs_pkg::LCS_RU_IDLE;
    end
    if (full_rst) begin
      next_s.cfg       = `LCS_CFG_RST;
      next_s.gptr      = '0;
      next_s.cu_base   = '0;
      next_s.ru_base   = '0;
      next_s.dump_addr = '0;
      next_s.hdr_size  = '0;
      next_s.irq_mask  = 1'b0;
      next_s.stat_sel  = '0;
      ev_clr           = '1;
    end
    // Command completion, or failed transmit when so configured
    if (s.cfg[`LCS_CFG_TNO_BIT]) begin
      ev_set[`LCS_EV_CX] = tx_bad;
    end else begin
      ev_set[`LCS_EV_CX] = (cmd_done || tx_copied) && cmd_ibit;
    end
    // Frame received; short frames are dropped, not reported
    ev_set[`LCS_EV_FR] = (frame_done && frame_len >= `LCS_MIN_FRAME) ||
      (header_done && s.cfg[`LCS_CFG_RFD_LSB +: 2] ==
       lcs_pkg::LCS_RFD_HEADER);
    next_s.rx_discard = frame_done && frame_len < `LCS_MIN_FRAME;
    // Command unit left active, or entered idle when so configured
    ev_set[`LCS_EV_CNA] = s.cu == lcs_pkg::LCS_CU_ACTIVE &&
      next_s.cu != lcs_pkg::LCS_CU_ACTIVE &&
      (!s.cfg[`LCS_CFG_CNAIDLE_BIT] ||
       next_s.cu == lcs_pkg::LCS_CU_IDLE);
    // Receive unit counts as ready in either ready state
    ru_was_ready = s.ru == lcs_pkg::LCS_RU_READY ||
                   s.ru == lcs_pkg::LCS_RU_READY_NORBD;
    ru_is_ready  = next_s.ru == lcs_pkg::LCS_RU_READY ||
                   next_s.ru == lcs_pkg::LCS_RU_READY_NORBD;
    ev_set[`LCS_EV_RNR] = ru_was_ready && !ru_is_ready;
    ev_set[`LCS_EV_MGMT] = mgmt_done && s.cfg[`LCS_CFG_MGMT_BIT];
    // Register reads
    if (rd) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = 2'b00;
      next_s.rdata  = '0;
      if (araddr == `LCS_OFF_STATUS) begin
        next_s.rdata[`LCS_ST_CU_LSB +: 2] = s.cu;
        next_s.rdata[`LCS_ST_RU_LSB +: 3] = s.ru;
        next_s.rdata[`LCS_ST_EV_LSB +: `LCS_EV_NUM] = ev_flags;
      end else if (araddr == `LCS_OFF_CMD) begin
        next_s.rdata[`LCS_CMD_MASK_BIT] = s.irq_mask;
      end else if (araddr == `LCS_OFF_PORT) begin
        next_s.rdata = '0;
      end else if (araddr == `LCS_OFF_GPTR) begin
        next_s.rdata = s.gptr;
      end else if (araddr == `LCS_OFF_CFG) begin
        next_s.rdata = s.cfg;
      end else if (araddr == `LCS_OFF_STAT_SEL) begin
        next_s.rdata[3:0] = s.stat_sel;
      end else if (araddr == `LCS_OFF_STAT_DATA) begin
        next_s.rdata = stat_value;
      end else begin
        next_s.rresp = 2'b10;
      end
    end
    // Transmit starts at the programmed FIFO level
    next_s.tx_start = tx_level >= thr_bytes;
    // Interrupt follows unmasked pending events
    next_s.irq = |ev_flags && !s.irq_mask;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s     <= '0;
      s.cfg <= `LCS_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  // Sticky events
  lcs_event_latch #(
    .N (`LCS_EV_NUM)
  ) u_events (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (ev_set),
    .clr     (ev_clr),
    .flags   (ev_flags)
  );

  // Statistics counters
  lcs_stats #(
    .N (`LCS_NUM_STATS),
    .W (32)
  ) u_stats (
    .aclk    (aclk),
    .aresetn (aresetn),
    .inc     (stat_inc),
    .clr     (s.dump_clr || full_rst),
    .sel     (s.stat_sel),
    .value   (stat_value)
  );

  // Outputs straight from the state register
  assign awready      = s.awready;
  assign wready       = s.wready;
  assign bvalid       = s.bvalid;
  assign bresp        = s.bresp;
  assign arready      = s.arready;
  assign rvalid       = s.rvalid;
  assign rresp        = s.rresp;
  assign rdata        = s.rdata;
  assign irq          = s.irq;
  assign cu_state     = s.cu;
  assign ru_state     = s.ru;
  assign cu_base      = s.cu_base;
  assign ru_base      = s.ru_base;
  assign dump_addr    = s.dump_addr;
  assign hdr_size     = s.hdr_size;
  assign dump_req     = s.dump_req;
  assign dump_clr     = s.dump_clr;
  assign selftest_req = s.selftest_req;
  assign tx_start     = s.tx_start;
  assign rx_discard   = s.rx_discard;
  assign tx_preempt   = s.cfg[`LCS_CFG_TXPRE_LSB +: 8];
  assign rx_preempt   = s.cfg[`LCS_CFG_RXPRE_LSB +: 8];
  assign rfd_format   = s.cfg[`LCS_CFG_RFD_LSB +: 2];
  assign adaptive_ifs = s.cfg[`LCS_CFG_AIFS_BIT];

  // Checks on the control behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  cu_start_a: assert property (
    cmd_wr && wstrb[0] && cu_cmd == lcs_pkg::LCS_CU_START &&
    !sel_rst |=> s.cu == lcs_pkg::LCS_CU_ACTIVE)
    else $error("CU start did not activate");
  ru_abort_a: assert property (
    cmd_wr && wstrb[0] && ru_cmd == lcs_pkg::LCS_RU_ABORT
    |=> s.ru == lcs_pkg::LCS_RU_IDLE)
    else $error("RU abort did not idle");
  swi_event_a: assert property (
    cmd_wr && wstrb[1] && wdata[`LCS_CMD_SWI_BIT] && !full_rst
    |=> ev_flags[`LCS_EV_SWI])
    else $error("Software event not raised");
  mask_irq_a: assert property (
    s.irq_mask |=> !irq)
    else $error("Masked interrupt asserted");
  cx_event_a: assert property (
    !s.cfg[`LCS_CFG_TNO_BIT] && cmd_done && cmd_ibit
    |=> ev_flags[`LCS_EV_CX])
    else $error("Command done event missing");
  fr_event_a: assert property (
    frame_done && frame_len >= `LCS_MIN_FRAME |=> ev_flags[`LCS_EV_FR])
    else $error("Frame event missing");
  cna_event_a: assert property (
    s.cu == lcs_pkg::LCS_CU_ACTIVE && !s.cfg[`LCS_CFG_CNAIDLE_BIT] ##1
    s.cu != lcs_pkg::LCS_CU_ACTIVE |-> ev_flags[`LCS_EV_CNA])
    else $error("Inactive event missing");
  rnr_event_a: assert property (
    $past(s.ru) == lcs_pkg::LCS_RU_READY &&
    s.ru == lcs_pkg::LCS_RU_IDLE |-> ev_flags[`LCS_EV_RNR])
    else $error("Not ready event missing");
  sel_reset_a: assert property (
    sel_rst |=> s.cu == lcs_pkg::LCS_CU_IDLE &&
    s.ru == lcs_pkg::LCS_RU_IDLE && $stable(s.cfg))
    else $error("Selective reset wrong");
  tx_thresh_a: assert property (
    tx_level < thr_bytes && $stable(s.cfg) |=> !tx_start)
    else $error("Transmit started below threshold");
  irq_drop_a: assert property (
    ev_flags == '0 [*2] |-> ##1 !irq)
    else $error("Interrupt with nothing pending");
  wr_resp_a: assert property (
    awvalid && wvalid && !s.bvalid && !s.awready |-> ##[1:2] bvalid)
    else $error("Write response late");

  cu_run_c: cover property (cmd_wr ##1 s.cu == lcs_pkg::LCS_CU_ACTIVE);
  ru_ready_c: cover property (s.ru == lcs_pkg::LCS_RU_READY_NORBD);
  irq_ack_c: cover property (irq ##1 ev_clr != '0 ##2 !irq);
  short_drop_c: cover property (rx_discard);
endmodule // lcs_ctrl

// File: test/lcs_dp_model.sv
// Datapath stand-in raising report pulses one cycle after a request
module lcs_dp_model (
  input  wire logic        aclk,
  input  wire logic [7:0]  ev,
  output logic             cmd_done,
  output logic             cmd_ibit,
  output logic             tx_bad,
  output logic             cu_list_end,
  output logic             frame_done,
  output logic [11:0]      frame_len,
  output logic             ru_suspend,
  output logic             ru_no_res,
  output logic             mgmt_done,
  output logic [15:0]      stat_inc,
  output logic             tx_copied,
  output logic             header_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q = 8'h00;
  // Request registered so each pulse lasts one cycle
  always @(posedge aclk) q <= ev;
  // Report pulses
  assign cmd_done = q[0];
  assign cmd_ibit = q[0] | q[1];
  assign tx_copied = q[1];
  assign header_done = q[7];
  assign tx_bad = q[1];
  assign cu_list_end = q[2];
  assign frame_done = q[3] | q[7];
  assign frame_len = q[7] ? 12'h03f : 12'h040;
  assign ru_suspend = q[4];
  assign ru_no_res = q[5];
  assign mgmt_done = q[6];
  assign stat_inc = {15'h0000, q[0]};
endmodule // lcs_dp_model

// File: test/tb.sv
// Register-level bench for the command/status unit
`include "lcs_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ev = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [11:0] tx_level = 12'h000, frame_len;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_start;
  logic        cmd_done, cmd_ibit, tx_bad, cu_list_end, frame_done;
  logic        ru_suspend, ru_no_res, mgmt_done, adaptive_ifs;
  logic        tx_copied, header_done, rx_discard;
  logic        dump_req, dump_clr, selftest_req;
  logic [3:0]  seen = 4'h0;
  logic [7:0]  tx_preempt, rx_preempt;
  logic [31:0] rdata, cu_base, ru_base, dump_addr, hdr_size;
  logic [1:0]  bresp, rresp, resp, cu_state, rfd_format;
  logic [2:0]  ru_state;
  logic [15:0] stat_inc;
  int          compares = 0, fail_count = 0;
  // Unit under test; rarely used reports held low
  lcs_ctrl lcs_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cmd_done,
    .cmd_ibit, .tx_copied, .tx_bad, .cu_list_end, .cu_suspend(1'b0),
    .frame_done, .frame_len, .header_done, .ru_suspend, .ru_no_res,
    .ru_no_rbd(1'b0), .ru_rbd_out(1'b0), .mgmt_done, .stat_inc, .tx_level,
    .irq, .cu_state, .ru_state, .cu_base, .ru_base, .dump_addr, .hdr_size,
    .dump_req, .dump_clr, .selftest_req, .tx_start, .rx_discard,
    .tx_preempt, .rx_preempt, .rfd_format, .adaptive_ifs);
  lcs_dp_model lcs_dp_model_inst (.aclk, .ev, .cmd_done, .cmd_ibit, .tx_bad,
    .cu_list_end, .frame_done, .frame_len, .ru_suspend, .ru_no_res,
    .mgmt_done, .stat_inc, .tx_copied, .header_done);
  // Sticky record of one-cycle request pulses
  always @(posedge aclk) begin
    if (aresetn) begin
      seen <= seen | {selftest_req, dump_clr, dump_req, rx_discard};
    end
  end
  // 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // Value compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Register read with data compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    resp = rresp;
    chk(rdata, e);
    @(posedge aclk);
  endtask
  // Datapath report request, then time for flag and irq to settle
  task automatic fire(input logic [7:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 8'h00;
    repeat (4) @(posedge aclk);
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end
  // Test sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`LCS_OFF_CFG, `LCS_CFG_RST);
    chk({tx_preempt, rx_preempt, 13'h0, rfd_format, adaptive_ifs},
      32'h0808_0001);
    rd(`LCS_OFF_STATUS, 32'h0);
    rd(8'h1c, 32'h0);
    chk({30'h0, resp}, 32'h2);
    wr(8'h1c, 32'h0);
    chk({30'h0, resp}, 32'h2);
    $display("test reset done");
    wr(`LCS_OFF_CMD, 32'h11);
    rd(`LCS_OFF_STATUS, 32'h16);
    fire(8'h24);
    rd(`LCS_OFF_STATUS, 32'h0c0c);
    chk({31'h0, irq}, 32'h1);
    wr(`LCS_OFF_CMD, 32'h40);
    wr(`LCS_OFF_STATUS, 32'h0c00);
    rd(`LCS_OFF_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test units done");
    fire(8'h01);
    wstrb <= 4'h2;
    wr(`LCS_OFF_CMD, 32'h211);
    wstrb <= 4'hf;
    rd(`LCS_OFF_STATUS, 32'h2100);
    chk({31'h0, irq}, 32'h1);
    wr(`LCS_OFF_CMD, 32'h100);
    rd(`LCS_OFF_CMD, 32'h100);
    chk({31'h0, irq}, 32'h0);
    wr(`LCS_OFF_CMD, 32'h0);
    wr(`LCS_OFF_STATUS, 32'h2100);
    wr(`LCS_OFF_CFG, `LCS_CFG_RST | 32'h1);
    fire(8'h01);
    rd(`LCS_OFF_STATUS, 32'h0);
    fire(8'h02);
    rd(`LCS_OFF_STATUS, 32'h100);
    wr(`LCS_OFF_STATUS, 32'h100);
    wr(`LCS_OFF_CFG, `LCS_CFG_RST | 32'h20);
    chk({30'h0, rfd_format}, 32'h2);
    fire(8'h82);
    rd(`LCS_OFF_STATUS, 32'h0300);
    chk({28'h0, seen}, 32'h1);
    wr(`LCS_OFF_STATUS, 32'h0300);
    $display("test events done");
    wr(`LCS_OFF_CFG, `LCS_CFG_RST | 32'h4);
    fire(8'h40);
    fire(8'h80);
    rd(`LCS_OFF_STATUS, 32'h1000);
    fire(8'h08);
    rd(`LCS_OFF_STATUS, 32'h1200);
    wr(`LCS_OFF_STATUS, 32'h1200);
    tx_level <= 12'h07f;
    repeat (3) @(posedge aclk);
    chk({31'h0, tx_start}, 32'h0);
    tx_level <= 12'h080;
    repeat (3) @(posedge aclk);
    chk({31'h0, tx_start}, 32'h1);
    $display("test frames done");
    wr(`LCS_OFF_GPTR, 32'h1234_5678);
    chk({30'h0, resp}, 32'h0);
    wr(`LCS_OFF_CMD, 32'h54);
    chk(hdr_size, 32'h1234_5678);
    chk(dump_addr, 32'h1234_5678);
    wr(`LCS_OFF_GPTR, 32'h89ab_cdef);
    wr(`LCS_OFF_CMD, 32'h66);
    chk(cu_base, 32'h89ab_cdef);
    chk(ru_base, 32'h89ab_cdef);
    wr(`LCS_OFF_STAT_SEL, 32'h0);
    rd(`LCS_OFF_STAT_DATA, 32'h2);
    wr(`LCS_OFF_CMD, 32'h7);
    rd(`LCS_OFF_STAT_DATA, 32'h0);
    chk({28'h0, seen}, 32'h7);
    wr(`LCS_OFF_CMD, 32'h11);
    wr(`LCS_OFF_PORT, 32'h2);
    chk({27'h0, cu_state, ru_state}, 32'h0);
    rd(`LCS_OFF_CFG, `LCS_CFG_RST | 32'h4);
    wr(`LCS_OFF_PORT, 32'h1);
    chk({28'h0, seen}, 32'hf);
    wr(`LCS_OFF_PORT, 32'h0);
    rd(`LCS_OFF_CFG, `LCS_CFG_RST);
    chk(cu_base, 32'h0);
    $display("test pointers done");
    end_of_test();
  end
endmodule // tb
